/* rtl/acr_defs.vh */
// Constants for the converter setup register block
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH
`define ACR_SETUP_SEL 3'h2
`define ACR_SETUP_RESET 24'h000117
`define ACR_SETUP_W 24
`define ACR_BIT_CHOP 23
`define ACR_BIT_FIX22 22
`define ACR_BIT_FIX21 21
`define ACR_BIT_REFERENCE_SOURCE_SELECT 20
`define ACR_BIT_PSEUDO 18
`define ACR_BIT_TEMP 16
`define ACR_CH_HI 15
`define ACR_CH_LO 8
`define ACR_BIT_BURN 7
`define ACR_BIT_REFERENCE_MISSING_DETECT_ENABLE 6
`define ACR_BIT_FIX5 5
`define ACR_BIT_BUF 4
`define ACR_BIT_POL 3
`define ACR_GAIN_HI 2
`define ACR_GAIN_LO 0
`define ACR_CONV_MS_PLAIN 20
`define ACR_SETTLE_MS_PLAIN 80
`define ACR_FILTER_WORD_REF 10'h060
`endif

/* rtl/acr_shift.v */
// Bit-serial shifter for one 24-bit register transfer, MSB first
`timescale 1ns/1ns
`include "acr_defs.vh"
module acr_shift (
   input wire core_clk,
   input wire reset,
   input wire load,
   input wire [23:0] load_word,
   input wire shift_en,
   input wire sdi,
   output wire sdo,
   output wire [23:0] word
);
   reg [23:0] sh_r;
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sh_r <= 24'h000000;
      end else if (load) begin
         sh_r <= load_word;
      end else if (shift_en) begin
         sh_r <= {sh_r[22:0], sdi};
      end
   end
   assign sdo = sh_r[23];
   assign word = sh_r;
endmodule

/* rtl/acr_setup.v */
// Converter setup register reached over the three-wire serial port
//
// What this block does
// - Selected by code 010, resets to 0x000117
// - 24 bits wide, read and write
// - Serial order is bit 23 first
// - Fixed field positions from 23 down to 0
// - Reset ones only at bits 8, 4, 2..0
// - Fields drive polarity, buffer, burnout, gain, channel
// - Chop off: 20 ms conversion, 80 ms settling
// - Chop on: offset removed, slower conversion
`timescale 1ns/1ns
`include "acr_defs.vh"
module acr_setup (
   input wire core_clk,
   input wire reset,
   input wire cs_n_pin,
   input wire sclk_pin,
   input wire din_pin,
   output reg dout_r,
   output reg dout_oe_r,
   output reg chop_enable_r,
   output reg reference_source_select_r,
   output reg pseudo_diff_select_r,
   output reg temp_sensor_select_r,
   output reg [7:0] input_select_r,
   output reg burnout_enable_r,
   output reg reference_missing_detect_enable_r,
   output reg buffer_enable_r,
   output reg unipolar_r,
   output reg [2:0] gain_code_r,
   output reg conv_slow_r
);
   // ---------------------------------------------------------------
   // Pin synchronisers: change accepted when stages two and three agree
   // ---------------------------------------------------------------
   reg [2:0] cs_s_r, ck_s_r, di_s_r;
   reg cs_n_r, sclk_r, din_r;
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cs_s_r <= 3'h7;
         ck_s_r <= 3'h0;
         di_s_r <= 3'h0;
         cs_n_r <= 1'b1;
         sclk_r <= 1'b0;
         din_r <= 1'b0;
      end else begin
         cs_s_r <= {cs_s_r[1:0], cs_n_pin};
         ck_s_r <= {ck_s_r[1:0], sclk_pin};
         di_s_r <= {di_s_r[1:0], din_pin};
         if (cs_s_r[1] == cs_s_r[2]) cs_n_r <= cs_s_r[2];
         if (ck_s_r[1] == ck_s_r[2]) sclk_r <= ck_s_r[2];
         if (di_s_r[1] == di_s_r[2]) din_r <= di_s_r[2];
      end
   end
   wire ck_new = (ck_s_r[1] == ck_s_r[2]) ? ck_s_r[2] : sclk_r;
   wire rise = ~cs_n_r & ck_new & ~sclk_r;
   wire fall = ~cs_n_r & ~ck_new & sclk_r;
   // ---------------------------------------------------------------
   // Frame: 8-bit command (bit6 read, bits 5..3 select) then 24 data bits
   // ---------------------------------------------------------------
   localparam ST_CMD = 3'b001;
   localparam ST_DATA = 3'b010;
   localparam ST_DONE = 3'b100;
   reg [2:0] state_r;
   reg [4:0] cnt_r;
   reg [7:0] cmd_r;
   reg rd_r;
   reg [23:0] setup_r;
   wire [23:0] sh_word;
   wire sh_sdo;
   wire cmd_last = (state_r == ST_CMD) && rise && (cnt_r == 5'h07);
   wire [7:0] cmd_full = {cmd_r[6:0], din_r};
   wire hit = (cmd_full[5:3] == `ACR_SETUP_SEL);
   wire sh_load = cmd_last & hit & cmd_full[6];
   wire sh_en = (state_r == ST_DATA) & rise;
   acr_shift u_shift (
      .core_clk(core_clk),
      .reset(reset),
      .load(sh_load),
      .load_word(setup_r),
      .shift_en(sh_en),
      .sdi(din_r),
      .sdo(sh_sdo),
      .word(sh_word)
   );
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_r <= ST_CMD;
         cnt_r <= 5'h00;
         cmd_r <= 8'h00;
         rd_r <= 1'b0;
         setup_r <= `ACR_SETUP_RESET;
         dout_r <= 1'b1;
         dout_oe_r <= 1'b0;
      end else if (cs_n_r) begin
         state_r <= ST_CMD;
         cnt_r <= 5'h00;
         dout_r <= 1'b1;
         dout_oe_r <= 1'b0;
      end else begin
         case (state_r)
            ST_CMD: begin
               if (rise) begin
                  cmd_r <= cmd_full;
                  cnt_r <= cnt_r + 5'h01;
                  if (cnt_r == 5'h07) begin
                     cnt_r <= 5'h00;
                     rd_r <= cmd_full[6];
                     state_r <= hit ? ST_DATA : ST_DONE;
                  end
               end
            end
            ST_DATA: begin
               if (rd_r) begin
                  dout_oe_r <= 1'b1;
                  if (fall || cnt_r == 5'h00) dout_r <= sh_sdo;
               end
               if (rise) begin
                  cnt_r <= cnt_r + 5'h01;
                  if (cnt_r == 5'h17) begin
                     state_r <= ST_DONE;
                     // Whole word committed at once, so fields never glitch mid-frame
                     if (!rd_r) setup_r <= {sh_word[22:0], din_r};
                  end
               end
            end
            ST_DONE: begin
               // Return to the idle level so a released line never shows a stale bit
               dout_r <= 1'b1;
               dout_oe_r <= 1'b0;
            end
            default: state_r <= ST_CMD;
         endcase
      end
   end
   // ---------------------------------------------------------------
   // Field decode to converter controls
   // ---------------------------------------------------------------
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         chop_enable_r <= 1'b0;
         reference_source_select_r <= 1'b0;
         pseudo_diff_select_r <= 1'b0;
         temp_sensor_select_r <= 1'b0;
         input_select_r <= 8'h01;
         burnout_enable_r <= 1'b0;
         reference_missing_detect_enable_r <= 1'b0;
         buffer_enable_r <= 1'b1;
         unipolar_r <= 1'b0;
         gain_code_r <= 3'h7;
         conv_slow_r <= 1'b0;
      end else begin
         chop_enable_r <= setup_r[`ACR_BIT_CHOP];
         // Chop lengthens conversion; plain timing is 20/80 ms at word 96
         conv_slow_r <= setup_r[`ACR_BIT_CHOP];
         reference_source_select_r <= setup_r[`ACR_BIT_REFERENCE_SOURCE_SELECT];
         pseudo_diff_select_r <= setup_r[`ACR_BIT_PSEUDO];
         temp_sensor_select_r <= setup_r[`ACR_BIT_TEMP];
         input_select_r <= setup_r[`ACR_CH_HI:`ACR_CH_LO];
         burnout_enable_r <= setup_r[`ACR_BIT_BURN];
         reference_missing_detect_enable_r <= setup_r[`ACR_BIT_REFERENCE_MISSING_DETECT_ENABLE];
         buffer_enable_r <= setup_r[`ACR_BIT_BUF];
         unipolar_r <= setup_r[`ACR_BIT_POL];
         gain_code_r <= setup_r[`ACR_GAIN_HI:`ACR_GAIN_LO];
      end
   end
endmodule

/* tb/acr_setup_assertions.sv */
// Port checker for the converter setup register
`timescale 1ns/1ns
module acr_setup_assertions (
   input wire core_clk, reset, cs_n_pin, sclk_pin, din_pin, dout_r, dout_oe_r,
   input wire chop_enable_r, reference_source_select_r, pseudo_diff_select_r,
   input wire temp_sensor_select_r, burnout_enable_r, reference_missing_detect_enable_r,
   input wire buffer_enable_r, unipolar_r, conv_slow_r,
   input wire [7:0] input_select_r,
   input wire [2:0] gain_code_r
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   wire [18:0] f = {chop_enable_r, reference_source_select_r, pseudo_diff_select_r,
      temp_sensor_select_r, input_select_r, burnout_enable_r,
      reference_missing_detect_enable_r, buffer_enable_r, unipolar_r, gain_code_r};
   property p_rst; $fell(reset) |-> f == 19'h00097; endproperty
   property p_idle; cs_n_pin [*6] |-> !dout_oe_r; endproperty
   property p_dout1; !dout_oe_r |-> dout_r; endproperty
   property p_slow; cs_n_pin [*8] |-> conv_slow_r == chop_enable_r; endproperty
   property p_hold; cs_n_pin [*6] |=> $stable(f); endproperty
   property p_first; $rose(dout_oe_r) |-> dout_r == chop_enable_r && !cs_n_pin; endproperty
   // Read data may only move once the serial clock has been low a while
   property p_shift; dout_oe_r && $past(dout_oe_r) && $changed(dout_r) |-> !$past(sclk_pin, 3);
   endproperty
   property p_off; $rose(cs_n_pin) |-> ##[1:6] !dout_oe_r; endproperty
   a_rst: assert property (p_rst) else $error("fields not at default");
   a_idle: assert property (p_idle) else $error("dout driven outside frame");
   a_dout1: assert property (p_dout1) else $error("dout not idle high");
   a_slow: assert property (p_slow) else $error("slow flag differs from chop");
   a_hold: assert property (p_hold) else $error("fields moved outside frame");
   a_first: assert property (p_first) else $error("first read bit wrong");
   a_shift: assert property (p_shift) else $error("dout moved while clock high");
   a_off: assert property (p_off) else $error("dout enable stuck after frame");
   c_read: cover property ($rose(dout_oe_r));
   c_write: cover property ($changed(f));
   c_chop: cover property ($rose(chop_enable_r));
endmodule
bind acr_setup acr_setup_assertions chk (.*);

/* tb/acr_host_model.sv */
// Host processor model on the three-wire serial port
`timescale 1ns/1ns
module acr_host_model (
   output logic cs_n,
   output logic sclk,
   output logic din,
   input wire logic dout
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      din = 1'b1;
   end
   // Half period of 8 core cycles leaves margin over the pin synchronisers
   task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int nb,
         output logic [23:0] rd);
      logic [31:0] sh;
      sh = {cmd, wd & ~24'h680020};
      cs_n = 1'b0;
      #80;
      for (int i = 0; i < nb; i++) begin
         sclk = 1'b0;
         din = sh[31 - i];
         #80;
         sclk = 1'b1;
         if (i > 7) rd = {rd[22:0], dout};
         #80;
      end
      cs_n = 1'b1;
      din = ~din;
      #160;
   endtask
endmodule

/* tb/acr_setup_test.sv */
// Self-checking bench for the converter setup register
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; \
   $display("Error %0t: got %h want %h", $time, a, b); end end
module acr_setup_test;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   wire cs_n_pin, sclk_pin, din_pin, dout_r, dout_oe_r, chop_enable_r, unipolar_r;
   wire reference_source_select_r, pseudo_diff_select_r, temp_sensor_select_r;
   wire burnout_enable_r, reference_missing_detect_enable_r, buffer_enable_r, conv_slow_r;
   wire [7:0] input_select_r;
   wire [2:0] gain_code_r;
   wire [18:0] fld = {chop_enable_r, reference_source_select_r, pseudo_diff_select_r,
      temp_sensor_select_r, input_select_r, burnout_enable_r,
      reference_missing_detect_enable_r, buffer_enable_r, unipolar_r, gain_code_r};
   int num_errors = 0;
   int n_compared = 0;
   logic [23:0] rd;
   logic [23:0] wv [2] = '{24'h91a5d9, 24'h045a46};
   acr_setup uut (.*);
   acr_host_model host (.cs_n(cs_n_pin), .sclk(sclk_pin), .din(din_pin),
      .dout(dout_oe_r ? dout_r : 1'b1));
   function automatic logic [18:0] pk(input logic [23:0] v);
      return {v[23], v[20], v[18], v[16], v[15:8], v[7], v[6], v[4:0]};
   endfunction
   task automatic close_out;
      if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #200000;
      num_errors++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      reset = 1'b0;
      repeat (4) @(negedge core_clk);
      `CHK(fld, 19'h00097)
      host.xfer(8'h50, 24'h0, 32, rd);
      `CHK(rd, 24'h000117)
      foreach (wv[i]) begin
         host.xfer(8'h10, wv[i], 32, rd);
         host.xfer(8'h50, 24'h0, 32, rd);
         `CHK(rd, wv[i])
         `CHK(fld, pk(wv[i]))
         `CHK(conv_slow_r, wv[i][23])
      end
      // Wrong select code, then a frame cut short: neither may write
      host.xfer(8'h18, 24'h000117, 32, rd);
      host.xfer(8'h10, 24'h000117, 20, rd);
      `CHK(fld, pk(wv[1]))
      close_out();
   end
endmodule
